/* common/mps_pkg.sv */
/*
  Shared constants for the Modbus RTU pressure register slave and its master.
  Assumes one 25 MHz system clock shared by both ends and a half-duplex pair.
*/
`default_nettype none
package mps_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Function codes
  localparam logic [7:0] FN_READ  = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  // Register numbers
  localparam logic [15:0] REG_ADDR  = 16'h0000;
  localparam logic [15:0] REG_SPEED = 16'h0001;
  localparam logic [15:0] REG_PAR   = 16'h0002;
  localparam logic [15:0] REG_DEC   = 16'h0003;
  localparam logic [15:0] REG_PRES  = 16'h0004;
  localparam logic [15:0] REG_UNIT  = 16'h0005;
  localparam logic [15:0] REG_COUNT = 16'h0006;
  // Values after reset and upper limits
  localparam logic [7:0] RST_NODE  = 8'h01;
  localparam logic [2:0] RST_SPEED = 3'h3;
  localparam logic [1:0] RST_PAR   = 2'h0;
  localparam logic [2:0] SPEED_MAX = 3'h6;
  localparam logic [1:0] PAR_MAX   = 2'h2;
  localparam logic [2:0] DEC_MAX   = 3'h4;
  // Line timing
  localparam int unsigned BAUD_DEF   = 19200;
  localparam int unsigned BIT_CYC    = CLK_HZ / BAUD_DEF;
  localparam int unsigned CHAR_BITS  = 11;
  localparam int unsigned GAP_CHARS  = 7;
  localparam int unsigned GAP_CYC    = BIT_CYC * CHAR_BITS * GAP_CHARS;
  localparam int unsigned TIMEOUT_MS = 1000;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned MAX_BYTES  = 8;
  // Master APB register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ARG    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0C;
  // Speed code to bit time in cycles
  function automatic logic [15:0] bit_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: bit_cycles = 16'(CLK_HZ / 2400);
      3'h1: bit_cycles = 16'(CLK_HZ / 4800);
      3'h2: bit_cycles = 16'(CLK_HZ / 9600);
      3'h3: bit_cycles = 16'(CLK_HZ / 19200);
      3'h4: bit_cycles = 16'(CLK_HZ / 38400);
      3'h5: bit_cycles = 16'(CLK_HZ / 57600);
      default: bit_cycles = 16'(CLK_HZ / 115200);
    endcase
  endfunction : bit_cycles
  // Modbus CRC-16 step over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    crc_byte = c;
  endfunction : crc_byte
endpackage : mps_pkg
`default_nettype wire

/* common/mps_link_if.sv */
/*
  RS-485 half-duplex pair between master and slave, each driving with an enable.
  The interface resolves the line, the master end winning; idle level is high.
*/
`default_nettype none
interface mps_link_if;
  logic m_tx;
  logic m_oe;
  logic s_tx;
  logic s_oe;
  logic line;
  // Resolved pair level, idle high when nobody drives
  assign line = m_oe ? m_tx : (s_oe ? s_tx : 1'b1);
  modport master (output m_tx, output m_oe, input line);
  modport slave  (output s_tx, output s_oe, input line);
endinterface : mps_link_if
`default_nettype wire

/* src/mps_slave.sv */
/*
  Modbus RTU register slave for a pressure transmitter: parses requests,
  serves function 03 and 06, answers over the shared pair.
  Assumes the pressure, decimal count and unit arrive from sensor logic on sys_clk.
*/
// Functional notes
// - Function 03 reads registers from map
// - Read request: addr, fn, start, count, CRC
// - Read reply: addr, fn, 2*count, data, CRC
// - Function 06 writes one register
// - Write reply echoes request exactly
// - Register 4 returns signed pressure, read-only
// - Master reads decimal count first
// - Master scales by ten to decimal count
// - Register 3 holds decimal count 0..4
// - Register 0 holds bus address 1..255
// - Register 1 selects line speed 0..6
// - Register 2 selects parity none/odd/even
// - Register 5 returns unit code, read-only
// - Default 8N1 at 19200 baud
// - Seven idle characters delimit frames; the slave counts the gap at 19200 baud for every speed code
// - Master timeout one second, no delay
`default_nettype none
module mps_slave (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Link
  mps_link_if.slave        link,
  // Sensor values
  input  wire logic [15:0] pressure,
  input  wire logic [2:0]  decimals,
  input  wire logic [7:0]  unit_code,
  // Current configuration
  output logic [7:0]       node_addr,
  output logic [2:0]       speed_code,
  output logic [1:0]       parity_code
);
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} mps_bit_e;

  logic        rx_s1, rx_s2;
  logic [15:0] bit_len;
  logic [15:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_sh;
  mps_bit_e    rx_st;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  logic [31:0] gap_cnt;
  logic [7:0]  frm [0:7];
  logic [3:0]  frm_n;
  logic [15:0] frm_crc;
  logic        rx_hold;
  // Transmit side
  logic [7:0]  tx_buf [0:8]; // Header plus up to three registers
  logic [3:0]  tx_len, tx_idx;
  logic        tx_busy;
  mps_bit_e    tx_st;
  logic [15:0] tx_cnt;
  logic [2:0]  tx_bit;
  logic        tx_line, tx_oe;
  logic [15:0] tx_crc;

  assign bit_len = mps_pkg::bit_cycles(speed_code);
  assign link.s_tx = tx_line;
  assign link.s_oe = tx_oe;

  // Frame decode once the gap has closed a request of 8 bytes
  wire        gap_done = (gap_cnt == mps_pkg::GAP_CYC) && (frm_n == 4'd8);
  wire [15:0] f_reg    = {frm[2], frm[3]};
  wire [15:0] f_val    = {frm[4], frm[5]};
  wire        crc_ok   = (frm_crc == 16'h0000);
  wire        addr_ok  = (frm[0] == node_addr);
  wire        is_rd    = (frm[1] == mps_pkg::FN_READ);
  wire        is_wr    = (frm[1] == mps_pkg::FN_WRITE);
  wire        rd_ok    = is_rd && (f_val >= 16'd1) && (f_val <= 16'd3)
                         && ({1'b0, f_reg} + {1'b0, f_val} <= {1'b0, mps_pkg::REG_COUNT});
  wire        wr_ok    = is_wr && (((f_reg == mps_pkg::REG_ADDR) && (f_val >= 16'd1)
                         && (f_val <= 16'd255))
                         || ((f_reg == mps_pkg::REG_SPEED) && (f_val <= 16'(mps_pkg::SPEED_MAX)))
                         || ((f_reg == mps_pkg::REG_PAR) && (f_val <= 16'(mps_pkg::PAR_MAX))));
  wire        serve    = gap_done && crc_ok && addr_ok && (rd_ok || wr_ok) && !tx_busy;

  // Register map read port
  function automatic logic [15:0] reg_rd(input logic [15:0] r);
    unique case (r)
      mps_pkg::REG_ADDR:  reg_rd = {8'h00, node_addr};
      mps_pkg::REG_SPEED: reg_rd = {13'h0000, speed_code};
      mps_pkg::REG_PAR:   reg_rd = {14'h0000, parity_code};
      mps_pkg::REG_DEC:   reg_rd = {13'h0000, (decimals > mps_pkg::DEC_MAX)
                                   ? mps_pkg::DEC_MAX : decimals};
      mps_pkg::REG_PRES:  reg_rd = pressure;
      default:            reg_rd = {8'h00, unit_code};
    endcase
  endfunction : reg_rd

  // Receiver: two-flop sync then 8 data, optional parity, one stop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_st <= ST_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_s1 <= link.line;
      rx_s2 <= rx_s1;
      rx_stb <= 1'b0;
      unique case (rx_st)
        ST_IDLE: begin
          if (!rx_s2 && !tx_oe) begin
            rx_st <= ST_START;
            rx_cnt <= bit_len >> 1;
          end
        end
        ST_START: begin
          if (rx_cnt == 16'h0000) begin
            rx_st <= rx_s2 ? ST_IDLE : ST_DATA;
            rx_cnt <= bit_len;
            rx_bit <= 3'h0;
          end else rx_cnt <= rx_cnt - 16'h0001;
        end
        ST_DATA: begin
          if (rx_cnt == 16'h0000) begin
            rx_sh <= {rx_s2, rx_sh[7:1]};
            rx_cnt <= bit_len;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) rx_st <= (parity_code == 2'h0) ? ST_STOP : ST_PAR;
          end else rx_cnt <= rx_cnt - 16'h0001;
        end
        ST_PAR: begin
          // Parity bit is skipped; a bad character will fail the CRC anyway
          if (rx_cnt == 16'h0000) begin
            rx_st <= ST_STOP;
            rx_cnt <= bit_len;
          end else rx_cnt <= rx_cnt - 16'h0001;
        end
        ST_STOP: begin
          if (rx_cnt == 16'h0000) begin
            rx_st <= ST_IDLE;
            rx_stb <= rx_s2;
            rx_byte <= rx_sh;
          end else rx_cnt <= rx_cnt - 16'h0001;
        end
      endcase
    end
  end

  // Frame assembly: silence resets the frame, running CRC over the first 8 bytes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_cnt <= 32'h00000000;
      frm_n <= 4'h0;
      frm_crc <= 16'hFFFF;
      rx_hold <= 1'b0;
    end else if (rx_stb) begin
      gap_cnt <= 32'h00000000;
      if (frm_n < 4'd8) begin
        frm[frm_n[2:0]] <= rx_byte;
        frm_n <= frm_n + 4'h1;
        frm_crc <= mps_pkg::crc_byte(frm_crc, rx_byte);
      end else rx_hold <= 1'b1; // Over-long frame is dropped
    end else if (rx_st != ST_IDLE) begin
      gap_cnt <= 32'h00000000;
    end else if (gap_cnt < mps_pkg::GAP_CYC) begin
      gap_cnt <= gap_cnt + 32'h00000001;
    end else begin
      // Gap reached: frame closed, decode happens this cycle
      gap_cnt <= 32'h00000000;
      frm_n <= 4'h0;
      frm_crc <= 16'hFFFF;
      rx_hold <= 1'b0;
    end
  end

  // Config registers and reply build; illegal values are not stored and get no reply
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      node_addr <= mps_pkg::RST_NODE;
      speed_code <= mps_pkg::RST_SPEED;
      parity_code <= mps_pkg::RST_PAR;
      tx_len <= 4'h0;
    end else if (serve && !rx_hold) begin
      tx_buf[0] <= frm[0];
      tx_buf[1] <= frm[1];
      if (is_rd) begin
        tx_buf[2] <= 8'(f_val << 1);
        for (int i = 0; i < 3; i++) begin
          tx_buf[3 + 2 * i] <= 8'(reg_rd(f_reg + 16'(i)) >> 8);
          tx_buf[4 + 2 * i] <= 8'(reg_rd(f_reg + 16'(i)));
        end
        tx_len <= 4'(3 + 2 * f_val[1:0]);
      end else begin
        for (int i = 2; i < 6; i++) tx_buf[i] <= frm[i];
        tx_len <= 4'd6;
        unique case (f_reg[1:0])
          2'h0: node_addr <= f_val[7:0];
          2'h1: speed_code <= f_val[2:0];
          default: parity_code <= f_val[1:0];
        endcase
      end
    end else if (tx_busy) begin
      tx_len <= tx_len;
    end
  end

  // Transmitter: starts at once after decode, CRC appended low byte first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_st <= ST_IDLE;
      tx_line <= 1'b1;
      tx_oe <= 1'b0;
      tx_idx <= 4'h0;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'h0;
      tx_crc <= 16'hFFFF;
    end else if (!tx_busy) begin
      if (serve && !rx_hold) begin
        tx_busy <= 1'b1;
        tx_idx <= 4'h0;
        tx_crc <= 16'hFFFF;
        tx_st <= ST_IDLE;
        tx_oe <= 1'b1;
      end
    end else begin
      if (tx_cnt != 16'h0000) tx_cnt <= tx_cnt - 16'h0001;
      else begin
        tx_cnt <= bit_len - 16'h0001;
        unique case (tx_st)
          ST_IDLE: begin
            if (tx_idx == tx_len + 4'd2) begin
              tx_busy <= 1'b0;
              tx_oe <= 1'b0;
              tx_line <= 1'b1;
            end else begin
              if (tx_idx < tx_len) tx_crc <= mps_pkg::crc_byte(tx_crc, tx_buf[tx_idx]);
              tx_line <= 1'b0;
              tx_st <= ST_DATA;
              tx_bit <= 3'h0;
            end
          end
          ST_DATA: begin
            tx_line <= (tx_idx < tx_len) ? tx_buf[tx_idx][tx_bit]
                     : ((tx_idx == tx_len) ? tx_crc[tx_bit] : tx_crc[8 + tx_bit]);
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) tx_st <= (parity_code == 2'h0) ? ST_STOP : ST_PAR;
          end
          ST_PAR: begin
            tx_line <= (parity_code == 2'h1) ^ ^((tx_idx < tx_len) ? tx_buf[tx_idx]
                     : ((tx_idx == tx_len) ? tx_crc[7:0] : tx_crc[15:8]));
            tx_st <= ST_STOP;
          end
          default: begin
            tx_line <= 1'b1;
            tx_idx <= tx_idx + 4'h1;
            tx_st <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule : mps_slave
`default_nettype wire

/* src/mps_master.sv */
/*
  Modbus RTU master end: software orders a read or write over APB, the master
  frames it, sends it, and collects the answer or a one second timeout.
  Assumes the slave shares sys_clk and the pair; line runs 8N1 at 19200.
*/
`default_nettype none
module mps_master (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  mps_link_if.master       link
);
  typedef enum logic [1:0] {MS_IDLE, MS_SEND, MS_WAIT} mps_ms_e;
  localparam logic [15:0] BITC = 16'(mps_pkg::BIT_CYC);
  mps_ms_e     st;
  logic [31:0] arg;
  logic [7:0]  fr [0:7];
  logic [3:0]  idx, bitn;
  logic [15:0] cnt, crc, rcrc;
  logic [9:0]  sh;
  logic        rx_s1, rx_s2, rx_act;
  logic [15:0] rcnt;
  logic [3:0]  rbit, rn;
  logic [7:0]  rsh, rfn;
  logic [15:0] rdata;
  logic [31:0] tmo;
  logic        done, err;
  logic [31:0] quiet;

  // APB decode: zero wait state
  wire wr_ctrl = psel && penable && pwrite && (paddr == mps_pkg::OFS_CTRL);
  wire wr_arg  = psel && penable && pwrite && (paddr == mps_pkg::OFS_ARG);
  wire go      = wr_ctrl && (st == MS_IDLE);
  // Pair has been silent for a whole frame gap
  wire line_quiet = (quiet == mps_pkg::GAP_CYC);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      arg <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > mps_pkg::OFS_RDATA);
      if (wr_arg) arg <= pwdata;
      unique case (paddr)
        mps_pkg::OFS_ARG:    prdata <= arg;
        mps_pkg::OFS_STATUS: prdata <= {29'h0, err, done, st != MS_IDLE};
        mps_pkg::OFS_RDATA:  prdata <= {16'h0000, rdata};
        default:             prdata <= 32'h00000000;
      endcase
    end
  end

  // Frame send, then wait for reply; CTRL bit0 picks write (1) or read (0)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= MS_IDLE;
      idx <= 4'h0;
      bitn <= 4'h0;
      cnt <= 16'h0000;
      crc <= 16'hFFFF;
      sh <= 10'h3FF;
      tmo <= 32'h00000000;
      done <= 1'b0;
      err <= 1'b0;
      link.m_tx <= 1'b1;
      link.m_oe <= 1'b0;
    end else unique case (st)
      MS_IDLE: if (go) begin
        fr[0] <= arg[31:24];
        fr[1] <= pwdata[0] ? mps_pkg::FN_WRITE : mps_pkg::FN_READ;
        fr[2] <= 8'h00;
        fr[3] <= arg[23:16];
        fr[4] <= arg[15:8];
        fr[5] <= arg[7:0];
        st <= MS_SEND;
        idx <= 4'h0;
        bitn <= 4'd10;
        crc <= 16'hFFFF;
        done <= 1'b0;
        err <= 1'b0;
      end
      MS_SEND: begin
        if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
        else if (bitn == 4'd10) begin
          if (idx == 4'd8) begin
            st <= MS_WAIT;
            link.m_oe <= 1'b0;
            tmo <= 32'h00000000;
          end else if (!link.m_oe) begin
            // Drive only after a gap of silence, or the slave would glue two frames together
            if (line_quiet) link.m_oe <= 1'b1;
          end else begin
            sh <= {1'b1, (idx < 4'd6) ? fr[idx[2:0]]
                 : ((idx == 4'd6) ? crc[7:0] : crc[15:8]), 1'b0};
            if (idx < 4'd6) crc <= mps_pkg::crc_byte(crc, fr[idx[2:0]]);
            bitn <= 4'h0;
          end
        end else begin
          link.m_tx <= sh[0];
          sh <= {1'b1, sh[9:1]};
          cnt <= BITC - 16'h0001;
          bitn <= bitn + 4'h1;
          if (bitn == 4'd9) idx <= idx + 4'h1;
        end
      end
      default: begin
        tmo <= tmo + 32'h00000001;
        if (rn != 4'h0 && rcnt == 16'h0000 && !rx_act && rcrc == 16'h0000 && rn >= 4'd7) begin
          st <= MS_IDLE;
          done <= 1'b1;
        end else if (tmo == mps_pkg::TIMEOUT_CYC) begin
          st <= MS_IDLE;
          done <= 1'b1;
          err <= 1'b1;
        end
      end
    endcase
  end

  // Reply receiver: keeps the data word of a read or write reply
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_act <= 1'b0;
      rcnt <= 16'h0000;
      rbit <= 4'h0;
      rn <= 4'h0;
      rsh <= 8'h00;
      rfn <= 8'h00;
      rcrc <= 16'hFFFF;
      rdata <= 16'h0000;
      quiet <= mps_pkg::GAP_CYC;
    end else begin
      rx_s1 <= link.line;
      rx_s2 <= rx_s1;
      // Silence counter on the pair, saturating at the frame gap
      if (!rx_s2) quiet <= 32'h00000000;
      else if (!line_quiet) quiet <= quiet + 32'h00000001;
      if (st != MS_WAIT) begin
        rn <= 4'h0;
        rcrc <= 16'hFFFF;
        rx_act <= 1'b0;
      end else if (!rx_act) begin
        if (rcnt != 16'h0000) rcnt <= rcnt - 16'h0001;
        else if (!rx_s2) begin
          rx_act <= 1'b1;
          rcnt <= BITC + (BITC >> 1);
          rbit <= 4'h0;
        end
      end else if (rcnt != 16'h0000) rcnt <= rcnt - 16'h0001;
      else if (rbit == 4'd8) begin
        rx_act <= 1'b0;
        rcnt <= BITC >> 1;
        rn <= rn + 4'h1;
        rcrc <= mps_pkg::crc_byte(rcrc, rsh);
        if (rn == 4'h1) rfn <= rsh;
        if ((rfn == mps_pkg::FN_READ && rn == 4'd3) || (rfn == mps_pkg::FN_WRITE && rn == 4'd4))
          rdata[15:8] <= rsh;
        if ((rfn == mps_pkg::FN_READ && rn == 4'd4) || (rfn == mps_pkg::FN_WRITE && rn == 4'd5))
          rdata[7:0] <= rsh;
      end else begin
        rsh <= {rx_s2, rsh[7:1]};
        rcnt <= BITC - 16'h0001;
        rbit <= rbit + 4'h1;
      end
    end
  end
endmodule : mps_master
`default_nettype wire

/* test/mps_link_chk.sv */
/*
  Checker on the shared pair between the master and slave ends.
  Assumes the interface signals are wired in by name; one clock, sync reset.
*/
`default_nettype none
module mps_link_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pair signals
  input wire logic m_tx,
  input wire logic m_oe,
  input wire logic s_tx,
  input wire logic s_oe,
  input wire logic line
);
  localparam int unsigned BIT = mps_pkg::BIT_CYC;
  localparam int unsigned GAP = mps_pkg::GAP_CYC;
  logic        line_q;
  int unsigned run_cnt;
  int unsigned idle_cnt;
  wire logic   changed;
  assign changed = line != line_q;
  // Run length of the current level and time since the line was last low; both saturate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_q   <= 1'b1;
      run_cnt  <= 2 * GAP;
      idle_cnt <= 2 * GAP;
    end else begin
      line_q   <= line;
      run_cnt  <= changed ? 1 : (run_cnt < 2 * GAP ? run_cnt + 1 : run_cnt);
      idle_cnt <= !line ? 0 : (idle_cnt < 2 * GAP ? idle_cnt + 1 : idle_cnt);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_single_driver: assert property (!(m_oe && s_oe))
    else $error("both ends drive the pair");
  a_bit_width: assert property (changed && (m_oe || s_oe) |-> run_cnt >= BIT - 2)
    else $error("line level shorter than one bit");
  a_char_low_max: assert property (!line && !changed |-> run_cnt <= 9 * BIT + 4)
    else $error("line low longer than start and eight data bits");
  a_master_stop: assert property ($fell(m_oe) |-> $past(m_tx))
    else $error("master released pair outside stop level");
  a_slave_stop: assert property ($fell(s_oe) |-> $past(s_tx))
    else $error("slave released pair outside stop level");
  a_reply_gap: assert property ($rose(s_oe) |-> idle_cnt >= GAP - 2 * BIT)
    else $error("slave reply before the idle gap");
  a_reply_prompt: assert property ($rose(s_oe) |-> idle_cnt <= GAP + 12 * BIT)
    else $error("slave reply delayed past the gap");
  a_request_gap: assert property ($rose(m_oe) |-> idle_cnt >= GAP - 2 * BIT)
    else $error("master request before the idle gap");
endmodule : mps_link_chk
`default_nettype wire

/* test/tb_modbus_pressure_register_slave.sv */
/*
  Bench joining master and slave over the pair; software side drives APB.
  Assumes the package line timing; each exchange costs a few hundred thousand cycles.
*/
`default_nettype none
module tb_modbus_pressure_register_slave;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BIT = mps_pkg::BIT_CYC;
  logic        sys_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] r;
  logic        e;
  logic [15:0] pressure;
  logic [2:0]  decimals;
  logic [7:0]  unit_code;
  logic [7:0]  node_addr;
  logic [2:0]  speed_code;
  logic [1:0]  parity_code;
  logic [7:0]  seen[$];
  logic [7:0]  exp[$];
  logic [15:0] rd_exp[6] = '{16'h0000, 16'h0003, 16'h0000, 16'h0004, 16'h8000, 16'h0007};
  int          miscompares;
  int          check_count;
  mps_link_if i_mps_link_if ();
  mps_slave i_mps_slave (.sys_clk(sys_clk), .rst(rst), .link(i_mps_link_if.slave),
    .pressure(pressure), .decimals(decimals), .unit_code(unit_code),
    .node_addr(node_addr), .speed_code(speed_code), .parity_code(parity_code));
  mps_master i_mps_master (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_mps_link_if.master));
  mps_link_chk i_mps_link_chk (.sys_clk(sys_clk), .rst(rst), .m_tx(i_mps_link_if.m_tx),
    .m_oe(i_mps_link_if.m_oe), .s_tx(i_mps_link_if.s_tx), .s_oe(i_mps_link_if.s_oe),
    .line(i_mps_link_if.line));
  // Clock at 25 MHz
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, want);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // One APB transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a hang
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Own CRC over exp from index s, appended low byte first
  task automatic push_crc(input int s);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = s; i < exp.size(); i++) begin
      c = c ^ {8'h00, exp[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
  endtask : push_crc
  // One exchange: expected request and reply bytes, then compare with the pair
  task automatic xfer(input logic w6, input logic [7:0] sa, input logic [7:0] rg,
                      input logic [15:0] v, input logic [15:0] rd);
    int n;
    int s;
    seen.delete();
    exp = {sa, w6 ? 8'h06 : 8'h03, 8'h00, rg, v[15:8], v[7:0]};
    push_crc(0);
    s = exp.size();
    if (w6) exp = {exp, exp[0:5]};
    else exp = {exp, sa, 8'h03, 8'h02, rd[15:8], rd[7:0]};
    push_crc(s);
    apb(1'b1, mps_pkg::OFS_ARG, {sa, rg, v});
    apb(1'b1, mps_pkg::OFS_CTRL, {31'h0, w6});
    n = 0;
    do begin
      repeat (100) @(posedge sys_clk);
      apb(1'b0, mps_pkg::OFS_STATUS, 32'h0);
    end while (r[1:0] !== 2'b10 && ++n < 8000);
    check(r[2:0], 3'b010);
    apb(1'b0, mps_pkg::OFS_RDATA, 32'h0);
    if (!w6) check(r[15:0], rd);
    else check(r[15:0], v);
    check(seen.size(), exp.size());
    foreach (exp[i]) check(seen[i], exp[i]);
  endtask : xfer
  // Byte monitor on the resolved pair, sampling at bit centres
  initial begin : line_monitor
    logic [7:0] b;
    forever begin
      @(posedge sys_clk);
      if (i_mps_link_if.line === 1'b0) begin
        repeat (BIT / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge sys_clk);
          b[i] = i_mps_link_if.line;
        end
        seen.push_back(b);
        while (i_mps_link_if.line !== 1'b1) @(posedge sys_clk);
      end
    end
  end
  // Watchdog well beyond seven exchanges
  initial begin
    #200000000;
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {pressure, decimals, unit_code} = {16'h8000, 3'h7, 8'h07};
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(node_addr, 8'h01);
    check(speed_code, 3'h3);
    check(parity_code, 2'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(e, 1'b1);
    $display("test reset_values done");
    xfer(1'b0, 8'h01, 8'h00, 16'h0001, 16'h0001);
    $display("test read_node_address done");
    xfer(1'b1, 8'h01, 8'h00, 16'h0002, 16'h0000);
    check(node_addr, 8'h02);
    $display("test write_node_address done");
    for (int k = 1; k < 6; k++) begin
      xfer(1'b0, 8'h02, 8'(k), 16'h0001, rd_exp[k]);
      $display("test read_register %0d done", k);
    end
    print_verdict();
  end
endmodule : tb_modbus_pressure_register_slave
`default_nettype wire
